//--- rtl/mpto_consts.svh
// Offsets, reset values, field positions and timing counts of the monitor pulse train output.
// Assumes a 250 MHz pclk and a 32-bit APB with byte addresses.
`ifndef MPTO_CONSTS_SVH
`define MPTO_CONSTS_SVH

// Register byte offsets
`define MPTO_ADDR_W 12
`define MPTO_ADDR_SRC 12'h000
`define MPTO_ADDR_FREF 12'h004
`define MPTO_ADDR_CREF 12'h008
`define MPTO_ADDR_CAL 12'h00C
`define MPTO_ADDR_WPROT 12'h010
`define MPTO_ADDR_EXTD 12'h014
`define MPTO_ADDR_CMD 12'h018
`define MPTO_ADDR_DIAL 12'h01C
`define MPTO_ADDR_STAT 12'h020
`define MPTO_ADDR_PCNT 12'h024

// Calibration command bits
`define MPTO_CMD_ENTRY 0
`define MPTO_CMD_CONFIRM 1
`define MPTO_CMD_ABORT 2

// Monitor source codes
`define MPTO_SRC_FREQ 8'h01
`define MPTO_SRC_CURR 8'h02
`define MPTO_SRC_REF 8'h15
`define MPTO_SRC_RST 8'h01

// Reset values and ranges, quantities in 0.01 units
`define MPTO_FREF_RST 16'h1770
`define MPTO_FREF_MAX 16'h9C40
`define MPTO_CREF_MAX 16'hC350
`define MPTO_CREF_RST 16'h03E8
`define MPTO_WPROT_RST 8'h00
`define MPTO_WPROT_LOCK 8'h01
`define MPTO_EXTD_RST 16'h0000
`define MPTO_GAIN_RST 16'h1000
`define MPTO_GAIN_SHIFT 12

// Pulse rates in pulses/s, and held as pulses/s times 16
`define MPTO_PPS_FULL 1440
`define MPTO_PPS_MAX 2400
`define MPTO_RATE_FRAC 16
`define MPTO_RATE_FULL 16'h5A00
`define MPTO_RATE_MAX 16'h9600

// Clock and times
`define MPTO_CLK_HZ 250000000
`define MPTO_CLK_MHZ 250
`define MPTO_PHASE_W 48
`define MPTO_PHASE_STEP ((64'h1 << `MPTO_PHASE_W) / (64'(`MPTO_RATE_FRAC) * 64'(`MPTO_CLK_HZ)))
`define MPTO_PULSE_HI_NS 100000
`define MPTO_PULSE_HI_CYC ((`MPTO_PULSE_HI_NS * `MPTO_CLK_MHZ) / 1000)
`define MPTO_FLASH_MS 1000
`define MPTO_FLASH_CYC (`MPTO_FLASH_MS * `MPTO_CLK_MHZ * 1000)

`endif

//--- rtl/mpto_monitor_pulse_out.sv
// Monitor pulse train output: APB registers, source scaling, calibration sequence.
// Assumes drive core supplies output frequency and current in 0.01 units, synchronous to pclk.
//
// Summary of operation
// - With the frequency monitor selected, output frequency equal to the frequency reference gives 1440 pulses/s.
// - The frequency monitor rate is proportional to output frequency and never above 2400 pulses/s.
// - With the current monitor selected, output current equal to the current reference gives 1440 pulses/s.
// - The current monitor rate is proportional to output current and capped at 2400 pulses/s.
// - Both full-scale references take new values at any time, whatever the write protect selection holds.
// - Calibration is reachable only while the extended display selection is zero, and then ignores write protect.
// - Any selected source at its full-scale value gives 1440 pulses/s.
// - After reset, 60 Hz of output frequency maps to 1440 pulses/s.
// - Source code 21 gives a fixed 1440 pulses/s reference train independent of load.
// - With the default reference, the output saturates at its maximum once frequency reaches 100 Hz.
// - Calibration goes entry, confirm to show the monitor, dial adjusts scale, confirm stores and flashes done.
// - If stopped at calibration, a run command is needed so that live pulses appear; no motor is needed.
// - Calibration is allowed while running and in external operation mode.
// - The frequency reference accepts 0 to 400 Hz and resets to 60 Hz.
// - The current reference accepts 0 to 500 A and resets to the rated current.
`timescale 1ns/1ps
`include "mpto_consts.svh"
module mpto_monitor_pulse_out
#(
  parameter logic [15:0] RATED_CURRENT = `MPTO_CREF_RST,
  parameter int PULSE_HI_CYC = `MPTO_PULSE_HI_CYC,
  parameter int FLASH_CYC = `MPTO_FLASH_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MPTO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mpto_pkg::mpto_q16_t out_freq,
  input wire mpto_pkg::mpto_q16_t out_curr,
  input wire logic drive_running,
  input wire logic external_mode,
  output logic pulse_monitor_output,
  output logic parameter_mode_indicator,
  output logic cal_display_active,
  output logic cal_done_flash,
  output mpto_pkg::mpto_q16_t monitor_display
);
  import mpto_pkg::*;

  localparam int FW = $clog2(FLASH_CYC + 1);

  // Byte-address match for one register word
  function automatic logic reg_hit(input logic [`MPTO_ADDR_W-1:0] a, input logic [`MPTO_ADDR_W-1:0] off);
    reg_hit = (a[`MPTO_ADDR_W-1:2] == off[`MPTO_ADDR_W-1:2]);
  endfunction

  logic [7:0] src_q;
  logic [15:0] fref_q;
  logic [15:0] cref_q;
  logic [15:0] cal_q;
  logic [15:0] work_q;
  logic [15:0] work_d;
  logic [7:0] wprot_q;
  logic [15:0] extd_q;
  logic [31:0] pcnt_q;
  logic [31:0] prdata_q;
  logic [15:0] disp_q;
  logic [FW-1:0] flash_q;
  mpto_cal_state_e cal_q_st;
  mpto_cal_state_e cal_d_st;

  mpto_rate_if rif ();

  // Address decode
  wire hit_src = reg_hit(paddr, `MPTO_ADDR_SRC);
  wire hit_fref = reg_hit(paddr, `MPTO_ADDR_FREF);
  wire hit_cref = reg_hit(paddr, `MPTO_ADDR_CREF);
  wire hit_cal = reg_hit(paddr, `MPTO_ADDR_CAL);
  wire hit_wprot = reg_hit(paddr, `MPTO_ADDR_WPROT);
  wire hit_extd = reg_hit(paddr, `MPTO_ADDR_EXTD);
  wire hit_cmd = reg_hit(paddr, `MPTO_ADDR_CMD);
  wire hit_dial = reg_hit(paddr, `MPTO_ADDR_DIAL);
  wire hit_stat = reg_hit(paddr, `MPTO_ADDR_STAT);
  wire hit_pcnt = reg_hit(paddr, `MPTO_ADDR_PCNT);
  wire aligned = (paddr[1:0] == 2'h0);
  wire mapped = aligned & (hit_src | hit_fref | hit_cref | hit_cal | hit_wprot | hit_extd |
                           hit_cmd | hit_dial | hit_stat | hit_pcnt);

  // Refusals; the two references and calibration are exempt from write protect
  wire wp_lock = (wprot_q == `MPTO_WPROT_LOCK);
  wire cal_open = (extd_q == `MPTO_EXTD_RST);
  wire err_cal = (hit_cal | hit_cmd | hit_dial) & ~cal_open;
  wire err_wp = pwrite & (hit_src | hit_extd) & wp_lock;
  wire err_fref = pwrite & hit_fref & (pwdata > {16'h0000, `MPTO_FREF_MAX});
  wire err_cref = pwrite & hit_cref & (pwdata > {16'h0000, `MPTO_CREF_MAX});
  wire err_ro = pwrite & (hit_stat | hit_pcnt);
  wire any_err = ~mapped | err_cal | err_wp | err_fref | err_cref | err_ro;
  wire access = psel & penable;
  wire wr_ok = access & pwrite & ~any_err;

  // Zero-wait slave; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access & any_err;
  assign prdata = prdata_q;

  // Calibration commands and dial steps
  wire cmd_entry = wr_ok & hit_cmd & pwdata[`MPTO_CMD_ENTRY];
  wire cmd_confirm = wr_ok & hit_cmd & pwdata[`MPTO_CMD_CONFIRM];
  wire cmd_abort = wr_ok & hit_cmd & pwdata[`MPTO_CMD_ABORT];
  wire dial_wr = wr_ok & hit_dial;
  wire signed [17:0] dial_sum = $signed({2'b00, work_q}) + $signed({{2{pwdata[15]}}, pwdata[15:0]});
  wire [15:0] dial_clamp = dial_sum[17] ? 16'h0000 : (dial_sum[16] ? 16'hFFFF : dial_sum[15:0]);
  wire in_adjust = (cal_q_st == MPTO_CAL_ADJUST);
  wire flash_end = (flash_q == '0);

  // Calibration sequence; external mode and running do not hold it off
  always_comb
  begin
    cal_d_st = cal_q_st;
    work_d = work_q;
    case (cal_q_st)
      MPTO_CAL_IDLE:
      begin
        if (cmd_entry)
          cal_d_st = MPTO_CAL_SELECT;
      end
      MPTO_CAL_SELECT:
      begin
        if (cmd_abort)
          cal_d_st = MPTO_CAL_IDLE;
        else if (cmd_confirm)
        begin
          cal_d_st = MPTO_CAL_ADJUST;
          work_d = cal_q;
        end
      end
      MPTO_CAL_ADJUST:
      begin
        if (cmd_abort)
          cal_d_st = MPTO_CAL_IDLE;
        else if (cmd_confirm)
          cal_d_st = MPTO_CAL_DONE;
        else if (dial_wr)
          work_d = dial_clamp;
      end
      MPTO_CAL_DONE:
      begin
        if (flash_end)
          cal_d_st = MPTO_CAL_IDLE;
      end
      default:
        cal_d_st = MPTO_CAL_IDLE;
    endcase
    if (!cal_open)
      cal_d_st = MPTO_CAL_IDLE;
  end

  // Calibration state, working gain and flash timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cal_q_st <= MPTO_CAL_IDLE;
      work_q <= `MPTO_GAIN_RST;
      flash_q <= '0;
    end
    else
    begin
      cal_q_st <= cal_d_st;
      work_q <= work_d;
      if (in_adjust && cmd_confirm)
        flash_q <= FW'(FLASH_CYC - 1);
      else if (!flash_end)
        flash_q <= flash_q - FW'(1);
    end
  end

  // Software registers; references writable in any mode while running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_q <= `MPTO_SRC_RST;
      fref_q <= `MPTO_FREF_RST;
      cref_q <= RATED_CURRENT;
      cal_q <= `MPTO_GAIN_RST;
      wprot_q <= `MPTO_WPROT_RST;
      extd_q <= `MPTO_EXTD_RST;
    end
    else
    begin
      if (wr_ok && hit_src)
        src_q <= pwdata[7:0];
      if (wr_ok && hit_fref)
        fref_q <= pwdata[15:0];
      if (wr_ok && hit_cref)
        cref_q <= pwdata[15:0];
      if (in_adjust && cmd_confirm)
        cal_q <= work_q;
      else if (wr_ok && hit_cal)
        cal_q <= pwdata[15:0];
      if (wr_ok && hit_wprot)
        wprot_q <= pwdata[7:0];
      if (wr_ok && hit_extd)
        extd_q <= pwdata[15:0];
    end
  end

  // Source scaling; stopped drive gives no live pulses except the fixed reference
  wire src_freq = (src_q == `MPTO_SRC_FREQ);
  wire src_curr = (src_q == `MPTO_SRC_CURR);
  wire src_ref = (src_q == `MPTO_SRC_REF);
  wire [15:0] qty = ~drive_running ? 16'h0000 : (src_freq ? out_freq : (src_curr ? out_curr : 16'h0000));
  wire [15:0] ref_sel = src_curr ? cref_q : fref_q;
  wire [15:0] gain = in_adjust ? work_q : cal_q;
  wire [47:0] prod = 48'(qty) * 48'(`MPTO_RATE_FULL) * 48'(gain);
  assign rif.numer = src_ref ? 35'(`MPTO_RATE_FULL) : prod[`MPTO_GAIN_SHIFT+34:`MPTO_GAIN_SHIFT];
  assign rif.denom = src_ref ? 16'h0001 : ref_sel;

  mpto_rate_div u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif)
  );

  mpto_pulse_gen #(.HI_CYC(PULSE_HI_CYC)) u_gen
  (
    .pclk(pclk),
    .presetn(presetn),
    .rif(rif)
  );

  // Status word: state, saturation, run, mode, live rate
  wire [31:0] stat_word = {rif.rate, 8'h00, 1'b0, external_mode, drive_running,
                           (rif.rate == `MPTO_RATE_MAX), cal_q_st};
  wire [31:0] rd_mux = ~aligned ? 32'h0000_0000 :
                       hit_src ? {24'h000000, src_q} :
                       hit_fref ? {16'h0000, fref_q} :
                       hit_cref ? {16'h0000, cref_q} :
                       (hit_cal && cal_open) ? {16'h0000, cal_q} :
                       hit_wprot ? {24'h000000, wprot_q} :
                       hit_extd ? {16'h0000, extd_q} :
                       (hit_dial && cal_open) ? {16'h0000, work_q} :
                       hit_stat ? stat_word :
                       hit_pcnt ? pcnt_q : 32'h0000_0000;

  // Read capture, pulse count and the monitor shown during adjustment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pcnt_q <= 32'h0000_0000;
      disp_q <= 16'h0000;
    end
    else
    begin
      if (psel && !penable && !pwrite)
        prdata_q <= rd_mux;
      if (rif.tick)
        pcnt_q <= pcnt_q + 32'h0000_0001; // Wraps; software takes differences
      disp_q <= in_adjust ? (src_curr ? out_curr : out_freq) : 16'h0000;
    end
  end

  assign pulse_monitor_output = rif.pulse;
  assign parameter_mode_indicator = (cal_q_st != MPTO_CAL_IDLE);
  assign cal_display_active = in_adjust;
  assign cal_done_flash = (cal_q_st == MPTO_CAL_DONE);
  assign monitor_display = disp_q;
endmodule // mpto_monitor_pulse_out

//--- rtl/mpto_pkg.sv
// Types shared by the monitor pulse train output modules.
// Constants live in mpto_consts.svh.
package mpto_pkg;

  typedef logic [15:0] mpto_q16_t;

  typedef enum logic [3:0]
  {
    MPTO_CAL_IDLE = 4'h1,
    MPTO_CAL_SELECT = 4'h2,
    MPTO_CAL_ADJUST = 4'h4,
    MPTO_CAL_DONE = 4'h8
  } mpto_cal_state_e;

endpackage

//--- rtl/mpto_pulse_gen.sv
// Phase accumulator that turns a rate word into a train of fixed-width pulses.
// Assumes the rate word is pulses/s times 16 at a 250 MHz clock.
`timescale 1ns/1ps
`include "mpto_consts.svh"
module mpto_pulse_gen
#(
  parameter int HI_CYC = `MPTO_PULSE_HI_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  mpto_rate_if.gen rif
);
  import mpto_pkg::*;

  localparam int HW = $clog2(HI_CYC + 1);
  localparam logic [16:0] STEP = 17'(`MPTO_PHASE_STEP);

  logic [`MPTO_PHASE_W-1:0] acc_q;
  logic [HW-1:0] hi_q;
  logic pulse_q;
  logic tick_q;

  // Increment proportional to the rate; carry out marks one pulse
  wire [32:0] inc = 33'(rif.rate) * 33'(STEP);
  wire [`MPTO_PHASE_W:0] sum = {1'b0, acc_q} + (`MPTO_PHASE_W + 1)'(inc);
  wire wrap = sum[`MPTO_PHASE_W];

  // Pulse high time is fixed; at the 2400/s cap the period still exceeds it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= '0;
      hi_q <= '0;
      pulse_q <= 1'b0;
      tick_q <= 1'b0;
    end
    else
    begin
      acc_q <= sum[`MPTO_PHASE_W-1:0];
      tick_q <= wrap;
      if (wrap)
      begin
        hi_q <= HW'(HI_CYC - 1);
        pulse_q <= 1'b1;
      end
      else
      begin
        pulse_q <= (hi_q != '0);
        if (hi_q != '0)
          hi_q <= hi_q - HW'(1);
      end
    end
  end

  assign rif.tick = tick_q;
  assign rif.pulse = pulse_q;
endmodule // mpto_pulse_gen

//--- rtl/mpto_rate_div.sv
// Sequential divider: rate = numer / denom, capped at the maximum pulse rate.
// Assumes numer and denom stay meaningful for the 17 cycles of one pass.
`timescale 1ns/1ps
`include "mpto_consts.svh"
module mpto_rate_div
(
  input wire logic pclk,
  input wire logic presetn,
  mpto_rate_if.div rif
);
  import mpto_pkg::*;

  logic [4:0] cnt_q;
  logic [34:0] num_q;
  logic [15:0] den_q;
  logic [15:0] rem_q;
  logic [15:0] quo_q;
  logic sat_q;
  logic [15:0] rate_q;

  // One restoring step per cycle
  wire [3:0] bit_idx = 4'(cnt_q - 5'h01);
  wire [16:0] trial = {rem_q, num_q[bit_idx]};
  wire ge = trial >= {1'b0, den_q};
  wire [15:0] rem_nx = ge ? 16'(trial - {1'b0, den_q}) : trial[15:0];
  wire [15:0] quo_nx = {quo_q[14:0], ge};
  // Quotient too wide means the cap applies anyway; zero reference saturates too
  wire sat_in = (rif.numer[34:16] >= {3'h0, rif.denom}) && (rif.numer != 35'h0);

  // Cap after gain, so a calibrated gain can never push past the limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 5'h00;
      num_q <= 35'h0;
      den_q <= 16'h0001;
      rem_q <= 16'h0000;
      quo_q <= 16'h0000;
      sat_q <= 1'b0;
      rate_q <= 16'h0000;
    end
    else if (cnt_q == 5'h00)
    begin
      num_q <= rif.numer;
      den_q <= rif.denom;
      rem_q <= rif.numer[31:16];
      quo_q <= 16'h0000;
      sat_q <= sat_in;
      cnt_q <= 5'h10;
    end
    else
    begin
      rem_q <= rem_nx;
      quo_q <= quo_nx;
      cnt_q <= cnt_q - 5'h01;
      // Zero quantity gives no pulses, even against a zero reference
      if (cnt_q == 5'h01)
        rate_q <= (num_q == 35'h0) ? 16'h0000 :
                  ((sat_q || quo_nx > `MPTO_RATE_MAX) ? `MPTO_RATE_MAX : quo_nx);
    end
  end

  assign rif.rate = rate_q;
endmodule // mpto_rate_div

//--- rtl/mpto_rate_if.sv
// Carrier between the control core, the rate divider and the pulse generator.
// Instantiated inside the top module only.
`timescale 1ns/1ps
interface mpto_rate_if;
  logic [34:0] numer;
  logic [15:0] denom;
  logic [15:0] rate;
  logic tick;
  logic pulse;

  modport ctl (output numer, output denom, input rate, input tick, input pulse);
  modport div (input numer, input denom, output rate);
  modport gen (input rate, output tick, output pulse);
endinterface

//--- tb/mpto_monitor_pulse_out_chk.sv
// Port-level assertions for the monitor pulse train output.
// Bound into the top module; sees its ports only, counts taken from its parameters.
`timescale 1ns/1ps
`include "mpto_consts.svh"
module mpto_monitor_pulse_out_chk
#(
  parameter int PULSE_HI_CYC = 4,
  parameter int FLASH_CYC = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`MPTO_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic pulse_monitor_output,
  input wire logic parameter_mode_indicator,
  input wire logic cal_display_active,
  input wire logic cal_done_flash,
  input wire mpto_pkg::mpto_q16_t monitor_display
);
  import mpto_pkg::*;
  logic [31:0] hi_q;
  logic [31:0] fl_q;
  wire wr_acc = psel && penable && pwrite;
  // Run lengths of pulse and flash; a counter avoids long repetitions
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hi_q <= '0;
      fl_q <= '0;
    end
    else
    begin
      hi_q <= pulse_monitor_output ? hi_q + 32'h1 : 32'h0;
      fl_q <= cal_done_flash ? fl_q + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pulse_width: assert property ($fell(pulse_monitor_output) |-> hi_q == PULSE_HI_CYC)
    else $error("pulse width wrong");
  a_flash_len: assert property ($fell(cal_done_flash) |-> fl_q == FLASH_CYC)
    else $error("flash length wrong");
  a_flash_from_adjust: assert property ($rose(cal_done_flash) |-> $fell(cal_display_active))
    else $error("flash without adjust");
  a_mode_lit: assert property (cal_display_active || cal_done_flash |-> parameter_mode_indicator)
    else $error("mode indicator off");
  a_display_idle: assert property (!$past(cal_display_active) |-> monitor_display == 16'h0)
    else $error("display outside adjust");
  a_fref_range: assert property (wr_acc && paddr == `MPTO_ADDR_FREF |-> pslverr == (pwdata > 32'h9C40))
    else $error("frequency reference range");
  a_cref_range: assert property (wr_acc && paddr == `MPTO_ADDR_CREF |-> pslverr == (pwdata > 32'hC350))
    else $error("current reference range");
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
endmodule // mpto_monitor_pulse_out_chk

bind mpto_monitor_pulse_out mpto_monitor_pulse_out_chk #(.PULSE_HI_CYC(PULSE_HI_CYC), .FLASH_CYC(FLASH_CYC)) u_chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .pulse_monitor_output,
  .parameter_mode_indicator, .cal_display_active, .cal_done_flash, .monitor_display
);

//--- tb/mpto_monitor_pulse_out_tb_top.sv
// Self-checking bench: APB master, drive-side inputs, pulse meter on the output.
// Short pulse and flash counts; pulse periods are far longer than the run, so none appear.
`timescale 1ns/1ps
`include "mpto_consts.svh"
module mpto_monitor_pulse_out_tb_top;
  import mpto_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`MPTO_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  mpto_q16_t out_freq = '0;
  mpto_q16_t out_curr = '0;
  logic drive_running = 1'b0;
  logic external_mode = 1'b0;
  logic pulse_monitor_output;
  logic parameter_mode_indicator;
  logic cal_display_active;
  logic cal_done_flash;
  mpto_q16_t monitor_display;
  logic [31:0] meter_count;
  logic [31:0] rd;
  logic er;
  int miscompares = 0;
  int total_checks = 0;

  // 250 MHz clock
  always #2 pclk = ~pclk;

  mpto_monitor_pulse_out #(.PULSE_HI_CYC(4), .FLASH_CYC(16)) DUT
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .out_freq, .out_curr, .drive_running, .external_mode, .pulse_monitor_output,
    .parameter_mode_indicator, .cal_display_active, .cal_done_flash, .monitor_display
  );
  mpto_pulse_meter u_meter (.pclk, .presetn, .pulse_in(pulse_monitor_output), .pulse_count(meter_count));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      miscompares++;
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", 32'(er), 32'(e));
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] v, input logic e);
    apb(1'b0, a, '0);
    chk("rdata", rd, v);
    chk("pslverr", 32'(er), 32'(e));
  endtask

  // Recompute takes up to 35 cycles after an input change
  task automatic rate_is(input logic [15:0] v);
    repeat (40) @(posedge pclk);
    apb(1'b0, `MPTO_ADDR_STAT, '0);
    chk("rate", 32'(rd[31:16]), 32'(v));
  endtask

  function automatic logic [15:0] exp_rate(input longint q, input longint g, input longint r);
    longint v;
    v = ((q * 23040 * g) >> `MPTO_GAIN_SHIFT) / r;
    return (v > 38400) ? `MPTO_RATE_MAX : v[15:0];
  endfunction

  task automatic s_resets();
    logic [11:0] a [7] = '{`MPTO_ADDR_SRC, `MPTO_ADDR_FREF, `MPTO_ADDR_CREF, `MPTO_ADDR_CAL,
                           `MPTO_ADDR_WPROT, `MPTO_ADDR_EXTD, `MPTO_ADDR_PCNT};
    logic [31:0] v [7] = '{32'h1, 32'h1770, 32'h3E8, 32'h1000, 32'h0, 32'h0, 32'h0};
    foreach (a[i])
      rdchk(a[i], v[i], 1'b0);
    rdchk(12'h030, 32'h0, 1'b1);
  endtask

  task automatic s_refs();
    wr(`MPTO_ADDR_WPROT, 32'h1, 1'b0);
    wr(`MPTO_ADDR_SRC, 32'h2, 1'b1);
    rdchk(`MPTO_ADDR_SRC, 32'h1, 1'b0);
    wr(`MPTO_ADDR_FREF, 32'h9C40, 1'b0);
    wr(`MPTO_ADDR_FREF, 32'h9C41, 1'b1);
    rdchk(`MPTO_ADDR_FREF, 32'h9C40, 1'b0);
    wr(`MPTO_ADDR_CREF, 32'hC350, 1'b0);
    wr(`MPTO_ADDR_CREF, 32'h1_0000, 1'b1);
    wr(`MPTO_ADDR_FREF, 32'h1770, 1'b0);
    wr(`MPTO_ADDR_CREF, 32'h3E8, 1'b0);
    wr(`MPTO_ADDR_WPROT, 32'h0, 1'b0);
  endtask

  task automatic s_rates();
    logic [15:0] f [4] = '{16'h1770, 16'h0BB8, 16'h2710, 16'h2EE0};
    logic [15:0] c [3] = '{16'h03E8, 16'h01F4, 16'h09C4};
    drive_running <= 1'b1;
    foreach (f[i])
    begin
      out_freq <= f[i];
      rate_is(exp_rate(f[i], 4096, 6000));
    end
    chk("cap", 32'(rd[4]), 32'h1);
    wr(`MPTO_ADDR_SRC, 32'h2, 1'b0);
    foreach (c[i])
    begin
      out_curr <= c[i];
      rate_is(exp_rate(c[i], 4096, 1000));
    end
    // Unknown source code gives no pulses
    wr(`MPTO_ADDR_SRC, 32'h3, 1'b0);
    rate_is(16'h0000);
    drive_running <= 1'b0;
    wr(`MPTO_ADDR_SRC, 32'h15, 1'b0);
    rate_is(`MPTO_RATE_FULL);
    wr(`MPTO_ADDR_SRC, 32'h1, 1'b0);
    rate_is(16'h0000);
  endtask

  task automatic s_cal();
    external_mode <= 1'b1;
    out_freq <= 16'h1F40;
    wr(`MPTO_ADDR_CMD, 32'h1, 1'b0);
    wr(`MPTO_ADDR_CMD, 32'h4, 1'b0);
    rdchk(`MPTO_ADDR_STAT, 32'h0000_0041, 1'b0);
    wr(`MPTO_ADDR_CMD, 32'h1, 1'b0);
    wr(`MPTO_ADDR_CMD, 32'h2, 1'b0);
    drive_running <= 1'b1;
    wr(`MPTO_ADDR_DIAL, 32'h800, 1'b0);
    rdchk(`MPTO_ADDR_DIAL, 32'h1800, 1'b0);
    rate_is(exp_rate(8000, 6144, 6000));
    chk("state", 32'(rd[3:0]), 32'h4);
    @(negedge pclk);
    chk("display", 32'(monitor_display), 32'h1F40);
    chk("mode", 32'(parameter_mode_indicator), 32'h1);
    wr(`MPTO_ADDR_CMD, 32'h2, 1'b0);
    @(negedge pclk);
    chk("flash", 32'(cal_done_flash), 32'h1);
    repeat (20) @(posedge pclk);
    rdchk(`MPTO_ADDR_CAL, 32'h1800, 1'b0);
    wr(`MPTO_ADDR_CAL, 32'h1000, 1'b0);
    external_mode <= 1'b0;
  endtask

  task automatic s_extd();
    wr(`MPTO_ADDR_EXTD, 32'h1, 1'b0);
    rdchk(`MPTO_ADDR_CAL, 32'h0, 1'b1);
    wr(`MPTO_ADDR_CMD, 32'h1, 1'b1);
    wr(`MPTO_ADDR_EXTD, 32'h0, 1'b0);
    wr(`MPTO_ADDR_WPROT, 32'h1, 1'b0);
    wr(`MPTO_ADDR_CAL, 32'hC00, 1'b0);
    rdchk(`MPTO_ADDR_CAL, 32'hC00, 1'b0);
    rdchk(`MPTO_ADDR_PCNT, 32'h0, 1'b0);
    chk("pulses", meter_count, 32'h0);
  endtask

  // Reset for 12 cycles, then the scenarios in turn
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    s_resets();
    s_refs();
    s_rates();
    s_cal();
    s_extd();
    stop_test();
  end
endmodule // mpto_monitor_pulse_out_tb_top

//--- tb/mpto_pulse_meter.sv
// Digital pulse counter on the pulse train output, standing for the far-side meter.
// Same clock as the block; counts rising edges only.
`timescale 1ns/1ps
module mpto_pulse_meter
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pulse_in,
  output logic [31:0] pulse_count
);
  logic last_q;
  // Edge count; a stuck-high line counts once, as a real counter would
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_q <= 1'b0;
      pulse_count <= '0;
    end
    else
    begin
      last_q <= pulse_in;
      if (pulse_in && !last_q)
        pulse_count <= pulse_count + 32'h1;
    end
  end
endmodule // mpto_pulse_meter
